//--- hw/orsd_decode.sv
// operand register-set decoder with word-write extension rules
`timescale 1ns/10ps

// Summary of operation
// - eight pointers: six address, index, stack pointer
// - seven pointers exclude the stack pointer
// - four-pointer set allows first four only
// - second index only on second dual read
// - modifier and fast return selectable alone
// - alu set: four accums, pair, three words
// - upper set routes accumulator upper portions
// - no-pair set omits the long pair
// - long set: four accumulators and pair
// - accumulator-only set picks one of four
// - data-word set picks among three words
// - single-bit set picks first two accumulators
// - two-accum upper set is source only
// - full move set: pair destination only
// - word write to pair clears low word
// - c/d ext and low via supplementary set
// - alu members other than the long pair get sign-extended word writes
// - control members get zero-extended word writes
module orsd_decode (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   req_valid_i,
    input  wire orsd_pkg::orsd_field_type field_kind_i,
    input  wire logic [4:0]             sel_idx_i,
    input  wire logic                   is_dest_i,
    input  wire logic                   first_access_i,
    input  wire logic [15:0]            wr_word_i,
    output logic                        dec_valid_o,
    output orsd_pkg::orsd_reg_type      reg_id_o,
    output orsd_pkg::orsd_part_type     part_o,
    output logic                        illegal_o,
    output logic                        wr_signed_o,
    output logic                        wr_low_clear_o,
    output logic [35:0]                 wr_data_o
);
    import orsd_pkg::*;

    // pointer table: six address registers, index, stack pointer
    localparam orsd_reg_type PTR_TAB [0:7] = '{
        ptr0, ptr1, ptr2, ptr3, ptr4, ptr5, ptr_index, stack_pointer
    };

    // data alu table: accumulators, long pair, data words
    localparam orsd_reg_type ALU_TAB [0:7] = '{
        acc_a, acc_b, acc_c, acc_d, long_pair,
        lone_data_word, pair_low_word, pair_high_word
    };

    // full cpu move set; c/d extension and low portions are absent
    localparam orsd_ent_type MOVE_TAB [0:30] = '{
        '{acc_a, pt_whole},
        '{acc_a, pt_ext},
        '{acc_a, pt_upper},
        '{acc_a, pt_low},
        '{acc_b, pt_whole},
        '{acc_b, pt_ext},
        '{acc_b, pt_upper},
        '{acc_b, pt_low},
        '{acc_c, pt_whole},
        '{acc_c, pt_upper},
        '{acc_d, pt_whole},
        '{acc_d, pt_upper},
        '{long_pair, pt_whole},
        '{pair_high_word, pt_whole},
        '{pair_low_word, pt_whole},
        '{lone_data_word, pt_whole},
        '{ptr0, pt_whole},
        '{ptr1, pt_whole},
        '{ptr2, pt_whole},
        '{ptr3, pt_whole},
        '{ptr4, pt_whole},
        '{ptr5, pt_whole},
        '{ptr_index, pt_whole},
        '{stack_pointer, pt_whole},
        '{modulo_modifier, pt_whole},
        '{second_index, pt_whole},
        '{operating_mode_word, pt_whole},
        '{status_word, pt_whole},
        '{loop_end_pointer, pt_whole},
        '{loop_count, pt_whole},
        '{hardware_loop_stack, pt_whole}
    };

    // supplementary set for the c and d extension and low portions
    localparam orsd_ent_type EXT_TAB [0:3] = '{
        '{acc_c, pt_ext},
        '{acc_d, pt_ext},
        '{acc_c, pt_low},
        '{acc_d, pt_low}
    };

    // registers that the stack can take 32 bits at a time
    localparam orsd_ent_type STACK_TAB [0:16] = '{
        '{acc_a, pt_ext},
        '{acc_b, pt_ext},
        '{acc_c, pt_ext},
        '{acc_d, pt_ext},
        '{pair_low_word, pt_whole},
        '{pair_high_word, pt_whole},
        '{lone_data_word, pt_whole},
        '{stack_pointer, pt_whole},
        '{modulo_modifier, pt_whole},
        '{second_index, pt_whole},
        '{loop_end_pointer, pt_whole},
        '{loop_end_pointer_hi, pt_whole},
        '{loop_count, pt_whole},
        '{loop_count_hi, pt_whole},
        '{hardware_loop_stack, pt_whole},
        '{operating_mode_word, pt_whole},
        '{status_word, pt_whole}
    };

    // data alu members are written signed, all others unsigned
    function automatic logic is_alu_reg(input orsd_reg_type id);
        is_alu_reg = (id >= acc_a) && (id <= pair_high_word);
    endfunction

    // decode one selector against its field; bad selections give illegal
    function automatic orsd_ent_type decode_sel(
        input orsd_field_type kind,
        input logic [4:0]     idx,
        input logic           dest,
        input logic           first,
        output logic          bad
    );
        orsd_ent_type e;
        e   = '{no_reg, pt_whole};
        bad = 1'b0;
        unique case (kind)
            fk_pointer_set_with_stack: begin
                bad = idx >= ORSD_N_PTR_STACK;
                e.id = PTR_TAB[idx[2:0]];
            end
            fk_pointer_set_seven: begin
                bad = idx >= ORSD_N_PTR_SEVEN;
                e.id = PTR_TAB[idx[2:0]];
            end
            fk_pointer_set_four: begin
                bad = idx >= ORSD_N_PTR_FOUR;
                e.id = PTR_TAB[idx[2:0]];
            end
            fk_second_index: begin
                // only the second access of a dual read may use it
                bad = (idx >= ORSD_N_SINGLE) || first;
                e.id = second_index;
            end
            fk_modulo_modifier: begin
                bad = idx >= ORSD_N_SINGLE;
                e.id = modulo_modifier;
            end
            fk_fast_irq_return_addr: begin
                bad = idx >= ORSD_N_SINGLE;
                e.id = fast_irq_return_addr;
            end
            fk_alu_all_set: begin
                bad = idx >= ORSD_N_ALU_ALL;
                e.id = ALU_TAB[idx[2:0]];
            end
            fk_alu_upper_portion_set: begin
                // skip the pair; accumulators route their upper portion
                bad = idx >= ORSD_N_ALU_SEVEN;
                e.id = ALU_TAB[(idx < 5'h04) ? idx[2:0] : 3'(idx + 5'h01)];
                if (idx < 5'h04) begin
                    e.part = pt_upper;
                end
            end
            fk_alu_no_pair_set: begin
                bad = idx >= ORSD_N_ALU_SEVEN;
                e.id = ALU_TAB[(idx < 5'h04) ? idx[2:0] : 3'(idx + 5'h01)];
            end
            fk_alu_long_set: begin
                bad = idx >= ORSD_N_ALU_LONG;
                e.id = ALU_TAB[idx[2:0]];
            end
            fk_accum_only_set: begin
                bad = idx >= ORSD_N_ACCUM;
                e.id = ALU_TAB[idx[2:0]];
            end
            fk_data_word_triple: begin
                bad = idx >= ORSD_N_DATA;
                e.id = ALU_TAB[3'(idx + ORSD_ALU_DATA_BASE)];
            end
            fk_accum_pair_set: begin
                bad = idx >= ORSD_N_ACC_PAIR;
                e.id = ALU_TAB[idx[2:0]];
            end
            fk_two_accum_upper_set: begin
                // upper portions here are read-only operands
                bad = (idx >= ORSD_N_ACC_PAIR) || dest;
                e = '{ALU_TAB[idx[2:0]], pt_upper};
            end
            fk_cpu_move_full_set: begin
                // the pair may be written but never read through this set
                bad = (idx >= ORSD_N_MOVE_FULL)
                    || (!dest && idx == ORSD_MOVE_PAIR_IDX);
                e = MOVE_TAB[(idx < ORSD_N_MOVE_FULL) ? idx : 5'h00];
            end
            fk_ext_low_cd_set: begin
                bad = idx >= ORSD_N_EXT_LOW;
                e = EXT_TAB[idx[1:0]];
            end
            fk_misc_stack_set: begin
                bad = idx >= ORSD_N_MISC_STACK;
                e = STACK_TAB[(idx < ORSD_N_MISC_STACK) ? idx : 5'h00];
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        // an illegal selection names no register so nothing is touched
        if (bad) begin
            e = '{no_reg, pt_whole};
        end
        decode_sel = e;
    endfunction

    orsd_state_type st_r;                // whole registered state
    orsd_state_type st_nxt;              // next state
    orsd_ent_type   ent;                 // current decode result
    logic           ent_bad;             // current selection illegal
    logic           ent_sgn;             // current write is signed
    logic [35:0]    fmt_data;            // formatted word write
    logic           fmt_low_clr;         // formatter clears low half

    // the formatter is kept separate so the extension rules live in one place
    orsd_word_fmt u_fmt (
        .word_i    (wr_word_i),
        .id_i      (ent.id),
        .part_i    (ent.part),
        .sgn_i     (ent_sgn),
        .data_o    (fmt_data),
        .low_clr_o (fmt_low_clr)
    );

    // decode the request; kept apart from the next-state process so the
    // formatter output never loops back into the process that feeds it
    always_comb begin
        ent_bad = 1'b0;
        ent     = decode_sel(field_kind_i, sel_idx_i, is_dest_i,
                             first_access_i, ent_bad);
        ent_sgn = is_alu_reg(ent.id);
    end

    // build the next state from the decode and the formatted word
    always_comb begin
        st_nxt  = st_r;
        st_nxt.valid = req_valid_i;
        if (req_valid_i) begin
            st_nxt.id      = ent.id;
            st_nxt.part    = ent.part;
            st_nxt.illegal = ent_bad;
            st_nxt.sgn     = ent_sgn;
            // an illegal access carries no write data
            st_nxt.low_clr = fmt_low_clr && !ent_bad;
            st_nxt.data    = ent_bad ? ORSD_RST_DATA : fmt_data;
        end
    end

    // register the state; a single cycle of latency
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '{1'b0, no_reg, pt_whole, 1'b0, 1'b0, 1'b0, ORSD_RST_DATA};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dec_valid_o    = st_r.valid;
    assign reg_id_o       = st_r.id;
    assign part_o         = st_r.part;
    assign illegal_o      = st_r.illegal;
    assign wr_signed_o    = st_r.sgn;
    assign wr_low_clear_o = st_r.low_clr;
    assign wr_data_o      = st_r.data;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // request steps used by several checks
    sequence s_req(orsd_field_type k);
        req_valid_i && field_kind_i == k;
    endsequence

    sequence s_pair_write;
        s_req(fk_cpu_move_full_set) ##0 (is_dest_i && sel_idx_i == ORSD_MOVE_PAIR_IDX);
    endsequence

    a_ptr_stack_top: assert property (s_req(fk_pointer_set_with_stack)
        ##0 (sel_idx_i == 5'h07) |=> reg_id_o == stack_pointer && !illegal_o)
        else $error("stack pointer not selected");
    a_ptr_seven_range: assert property (s_req(fk_pointer_set_seven)
        ##0 (sel_idx_i == 5'h07) |=> illegal_o && reg_id_o == no_reg)
        else $error("seven-pointer overrun accepted");
    a_ptr_four_range: assert property (s_req(fk_pointer_set_four)
        ##0 (sel_idx_i > 5'h03) |=> illegal_o)
        else $error("four-pointer overrun accepted");
    a_second_idx_first: assert property (s_req(fk_second_index)
        ##0 first_access_i |=> illegal_o)
        else $error("second index on first access");
    a_upper_route: assert property (s_req(fk_alu_upper_portion_set)
        ##0 (sel_idx_i < 5'h04) |=> part_o == pt_upper && !illegal_o)
        else $error("upper portion not routed");
    a_no_pair_set: assert property (s_req(fk_alu_no_pair_set)
        |=> reg_id_o != long_pair)
        else $error("pair offered in no-pair set");
    a_upper2_source: assert property (s_req(fk_two_accum_upper_set)
        ##0 is_dest_i |=> illegal_o)
        else $error("upper set used as destination");
    a_pair_src_bad: assert property (s_req(fk_cpu_move_full_set)
        ##0 (!is_dest_i && sel_idx_i == ORSD_MOVE_PAIR_IDX) |=> illegal_o)
        else $error("pair read accepted");
    a_pair_low_clear: assert property (s_pair_write |=> wr_low_clear_o
        && wr_data_o[15:0] == 16'h0000 && wr_data_o[31:16] == $past(wr_word_i))
        else $error("pair low word not cleared");
    a_sign_extend: assert property (dec_valid_o && wr_signed_o && part_o != pt_whole
        |-> wr_data_o[35:16] == {20{wr_data_o[15]}})
        else $error("word not sign-extended");
    a_zero_extend: assert property (dec_valid_o && !illegal_o && !wr_signed_o
        |-> wr_data_o[35:16] == 20'h00000)
        else $error("word not zero-extended");
    a_valid_track: assert property (req_valid_i ##1 1'b1 |-> dec_valid_o ##1 1'b1)
        else $error("decode result missing");

endmodule

//--- hw/orsd_pkg.sv
// shared constants and types for the operand register-set decoder
package orsd_pkg;

    localparam int ORSD_WORD_W = 16;            // width of a word write
    localparam int ORSD_ACC_W  = 36;            // full accumulator width
    localparam int ORSD_SEL_W  = 5;             // widest selector field

    // number of legal entries in each operand set
    localparam logic [4:0] ORSD_N_PTR_STACK  = 5'h08;
    localparam logic [4:0] ORSD_N_PTR_SEVEN  = 5'h07;
    localparam logic [4:0] ORSD_N_PTR_FOUR   = 5'h04;
    localparam logic [4:0] ORSD_N_SINGLE     = 5'h01;
    localparam logic [4:0] ORSD_N_ALU_ALL    = 5'h08;
    localparam logic [4:0] ORSD_N_ALU_SEVEN  = 5'h07;
    localparam logic [4:0] ORSD_N_ALU_LONG   = 5'h05;
    localparam logic [4:0] ORSD_N_ACCUM      = 5'h04;
    localparam logic [4:0] ORSD_N_DATA       = 5'h03;
    localparam logic [4:0] ORSD_N_ACC_PAIR   = 5'h02;
    localparam logic [4:0] ORSD_N_MOVE_FULL  = 5'h1f;
    localparam logic [4:0] ORSD_N_EXT_LOW    = 5'h04;
    localparam logic [4:0] ORSD_N_MISC_STACK = 5'h11;

    // positions inside the ordered tables
    localparam logic [4:0] ORSD_ALU_DATA_BASE = 5'h05; // first data word in alu table
    localparam logic [4:0] ORSD_MOVE_PAIR_IDX = 5'h0c; // long pair in full move set

    // reset value of the registered result word
    localparam logic [35:0] ORSD_RST_DATA = 36'h0_0000_0000;

    // which operand field of the instruction is being decoded
    typedef enum logic [4:0] {
        fk_pointer_set_with_stack = 5'b00000,
        fk_pointer_set_seven      = 5'b00001,
        fk_pointer_set_four       = 5'b00010,
        fk_second_index           = 5'b00011,
        fk_modulo_modifier        = 5'b00100,
        fk_fast_irq_return_addr   = 5'b00101,
        fk_alu_all_set            = 5'b00110,
        fk_alu_upper_portion_set  = 5'b00111,
        fk_alu_no_pair_set        = 5'b01000,
        fk_alu_long_set           = 5'b01001,
        fk_accum_only_set         = 5'b01010,
        fk_data_word_triple       = 5'b01011,
        fk_accum_pair_set         = 5'b01100,
        fk_two_accum_upper_set    = 5'b01101,
        fk_cpu_move_full_set      = 5'b01110,
        fk_ext_low_cd_set         = 5'b01111,
        fk_misc_stack_set         = 5'b10000
    } orsd_field_type;

    // cpu registers that a field can name
    typedef enum logic [5:0] {
        no_reg               = 6'b000000,
        acc_a                = 6'b000001,
        acc_b                = 6'b000010,
        acc_c                = 6'b000011,
        acc_d                = 6'b000100,
        long_pair            = 6'b000101,
        lone_data_word       = 6'b000110,
        pair_low_word        = 6'b000111,
        pair_high_word       = 6'b001000,
        ptr0                 = 6'b001001,
        ptr1                 = 6'b001010,
        ptr2                 = 6'b001011,
        ptr3                 = 6'b001100,
        ptr4                 = 6'b001101,
        ptr5                 = 6'b001110,
        ptr_index            = 6'b001111,
        stack_pointer        = 6'b010000,
        second_index         = 6'b010001,
        modulo_modifier      = 6'b010010,
        fast_irq_return_addr = 6'b010011,
        operating_mode_word  = 6'b010100,
        status_word          = 6'b010101,
        loop_end_pointer     = 6'b010110,
        loop_end_pointer_hi  = 6'b010111,
        loop_count           = 6'b011000,
        loop_count_hi        = 6'b011001,
        hardware_loop_stack  = 6'b011010
    } orsd_reg_type;

    // portion of the selected register
    typedef enum logic [1:0] {
        pt_whole = 2'b00,
        pt_ext   = 2'b01,
        pt_upper = 2'b10,
        pt_low   = 2'b11
    } orsd_part_type;

    // one table entry: register and portion
    typedef struct packed {
        orsd_reg_type  id;
        orsd_part_type part;
    } orsd_ent_type;

    // complete registered state of the decoder
    typedef struct packed {
        logic          valid;
        orsd_reg_type  id;
        orsd_part_type part;
        logic          illegal;
        logic          sgn;
        logic          low_clr;
        logic [35:0]   data;
    } orsd_state_type;

endpackage

//--- hw/orsd_word_fmt.sv
// word-write formatter: extends a 16-bit word into the target register
`timescale 1ns/10ps
module orsd_word_fmt (
    input  wire logic [15:0]           word_i,
    input  wire orsd_pkg::orsd_reg_type id_i,
    input  wire orsd_pkg::orsd_part_type part_i,
    input  wire logic                  sgn_i,
    output logic      [35:0]           data_o,
    output logic                       low_clr_o
);
    import orsd_pkg::*;

    // accumulators written whole take the word in their upper portion
    always_comb begin
        low_clr_o = 1'b0;
        if (id_i == long_pair && part_i == pt_whole) begin
            // high word loaded, low word forced to zero
            data_o    = {4'h0, word_i, 16'h0000};
            low_clr_o = 1'b1;
        end else if (id_i >= acc_a && id_i <= acc_d && part_i == pt_whole) begin
            data_o    = {{4{word_i[15]}}, word_i, 16'h0000};
            low_clr_o = 1'b1;
        end else if (sgn_i) begin
            data_o = {{20{word_i[15]}}, word_i};
        end else begin
            data_o = {20'h00000, word_i};
        end
    end

endmodule

//--- testbench/operand_register_set_decode_tb.sv
// self-checking bench for the operand register-set decoder
`timescale 1ns/10ps
module operand_register_set_decode_tb;
    import orsd_pkg::*;
    logic                core_clk_i;   // 40 MHz core clock
    logic                rst_i;        // asynchronous reset, active high
    logic                req_valid;
    orsd_field_type      field_kind;
    logic [4:0]          sel_idx;
    logic                is_dest;
    logic                first_access;
    logic [15:0]         wr_word;
    logic                dec_valid;
    orsd_reg_type        reg_id;
    orsd_part_type       part;
    logic                illegal;
    logic                wr_signed;
    logic                wr_low_clear;
    logic [35:0]         wr_data;
    int                  miscompares;  // mismatches seen
    int                  cmp_count;    // comparisons made

    orsd_core_model core_u (.core_clk_i(core_clk_i), .req_valid_o(req_valid),
        .field_kind_o(field_kind), .sel_idx_o(sel_idx), .is_dest_o(is_dest),
        .first_access_o(first_access), .wr_word_o(wr_word));
    orsd_decode dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .field_kind_i(field_kind), .sel_idx_i(sel_idx), .is_dest_i(is_dest),
        .first_access_i(first_access), .wr_word_i(wr_word), .dec_valid_o(dec_valid),
        .reg_id_o(reg_id), .part_o(part), .illegal_o(illegal), .wr_signed_o(wr_signed),
        .wr_low_clear_o(wr_low_clear), .wr_data_o(wr_data));

    // clock, half period 12.5 ns
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // one comparison; case inequality so an unknown never matches
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // legal answer: register, portion, sign flag, low clear, formatted word
    task automatic ok(input orsd_reg_type id, input orsd_part_type pt, input logic sg,
                      input logic lc, input logic [35:0] d);
        check(36'(dec_valid), 36'h1);
        check(36'(reg_id), 36'(id));
        check(36'(part), 36'(pt));
        check(36'(illegal), 36'h0);
        check(36'(wr_signed), 36'(sg));
        check(36'(wr_low_clear), 36'(lc));
        check(wr_data, d);
    endtask

    // refused selection answered as illegal with nothing to write
    task automatic bad();
        check(36'(dec_valid), 36'h1);
        check(36'(illegal), 36'h1);
        check(36'(reg_id), 36'(no_reg));
        check(36'(wr_low_clear), 36'h0);
        check(wr_data, 36'h0);
    endtask

    // reset state of every output
    task automatic test_reset();
        check({dec_valid, illegal, wr_signed, wr_low_clear}, 36'h0);
        check(36'(reg_id), 36'(no_reg));
        check(36'(part), 36'(pt_whole));
        check(wr_data, 36'h0);
        $display("test reset done");
    endtask

    // pointer sets: every legal entry, then the first one past the end
    task automatic test_pointers();
        orsd_field_type ks[3] = '{fk_pointer_set_with_stack, fk_pointer_set_seven,
                                  fk_pointer_set_four};
        int ns[3] = '{8, 7, 4};
        orsd_reg_type exp_id;    // entry i of the pointer order
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i <= ns[k]; i++) begin
                exp_id = orsd_reg_type'(6'(ptr0) + 6'(i));
                core_u.send(ks[k], 5'(i), 1'b1, 1'b0, 16'h8001, 1'b0);
                if (i < ns[k]) begin
                    ok(exp_id, pt_whole, 1'b0, 1'b0, 36'h8001);
                end else begin
                    bad();
                end
            end
        end
        $display("test pointers done");
    endtask

    // lone agu registers and the second-access restriction
    task automatic test_single();
        core_u.send(fk_second_index, 5'h00, 1'b0, 1'b1, 16'h0001, 1'b0);
        bad();
        core_u.send(fk_second_index, 5'h00, 1'b0, 1'b0, 16'h0001, 1'b0);
        ok(second_index, pt_whole, 1'b0, 1'b0, 36'h1);
        core_u.send(fk_modulo_modifier, 5'h00, 1'b1, 1'b0, 16'h0001, 1'b0);
        ok(modulo_modifier, pt_whole, 1'b0, 1'b0, 36'h1);
        core_u.send(fk_fast_irq_return_addr, 5'h00, 1'b1, 1'b0, 16'h0001, 1'b0);
        ok(fast_irq_return_addr, pt_whole, 1'b0, 1'b0, 36'h1);
        core_u.send(fk_fast_irq_return_addr, 5'h01, 1'b1, 1'b0, 16'h0001, 1'b0);
        bad();
        $display("test single done");
    endtask

    // alu operand sets at their boundaries
    task automatic test_alu();
        core_u.send(fk_alu_all_set, 5'h04, 1'b1, 1'b0, 16'h8001, 1'b0);
        ok(long_pair, pt_whole, 1'b1, 1'b1, 36'h0_8001_0000);
        core_u.send(fk_alu_upper_portion_set, 5'h03, 1'b0, 1'b0, 16'h0001, 1'b0);
        check(36'(part), 36'(pt_upper));
        core_u.send(fk_alu_no_pair_set, 5'h04, 1'b0, 1'b0, 16'h0001, 1'b0);
        check(36'(reg_id), 36'(lone_data_word));
        core_u.send(fk_alu_long_set, 5'h05, 1'b1, 1'b0, 16'h0001, 1'b0);
        bad();
        core_u.send(fk_accum_only_set, 5'h03, 1'b1, 1'b0, 16'h0001, 1'b0);
        check(36'(reg_id), 36'(acc_d));
        core_u.send(fk_data_word_triple, 5'h03, 1'b1, 1'b0, 16'h0001, 1'b0);
        bad();
        core_u.send(fk_accum_pair_set, 5'h02, 1'b1, 1'b0, 16'h0001, 1'b0);
        bad();
        core_u.send(fk_two_accum_upper_set, 5'h01, 1'b1, 1'b0, 16'h0001, 1'b0);
        bad();
        $display("test alu done");
    endtask

    // full move set: pair direction, extension, c/d portions, stack set
    task automatic test_move();
        core_u.send(fk_cpu_move_full_set, 5'h0c, 1'b0, 1'b0, 16'h8001, 1'b0);
        bad();
        core_u.send(fk_cpu_move_full_set, 5'h00, 1'b1, 1'b0, 16'h8001, 1'b0);
        ok(acc_a, pt_whole, 1'b1, 1'b1, 36'hf_8001_0000);
        core_u.send(fk_cpu_move_full_set, 5'h0f, 1'b1, 1'b0, 16'h8001, 1'b0);
        ok(lone_data_word, pt_whole, 1'b1, 1'b0, 36'hf_ffff_8001);
        core_u.send(fk_cpu_move_full_set, 5'h1b, 1'b1, 1'b0, 16'h8001, 1'b0);
        ok(status_word, pt_whole, 1'b0, 1'b0, 36'h0_0000_8001);
        core_u.send(fk_cpu_move_full_set, 5'h1f, 1'b1, 1'b0, 16'h8001, 1'b0);
        bad();
        core_u.send(fk_ext_low_cd_set, 5'h03, 1'b1, 1'b0, 16'h0001, 1'b0);
        check({30'h0, reg_id}, 36'(acc_d));
        check(36'(part), 36'(pt_low));
        core_u.send(fk_misc_stack_set, 5'h10, 1'b1, 1'b0, 16'h0001, 1'b0);
        check(36'(reg_id), 36'(status_word));
        core_u.send(fk_misc_stack_set, 5'h11, 1'b1, 1'b0, 16'h0001, 1'b0);
        bad();
        $display("test move done");
    endtask

    // back-to-back requests answer every cycle, then valid drops
    task automatic test_burst();
        core_u.send(fk_cpu_move_full_set, 5'h0c, 1'b1, 1'b0, 16'h8001, 1'b1);
        ok(long_pair, pt_whole, 1'b1, 1'b1, 36'h0_8001_0000);
        core_u.send(fk_cpu_move_full_set, 5'h17, 1'b1, 1'b0, 16'h00ff, 1'b0);
        ok(stack_pointer, pt_whole, 1'b0, 1'b0, 36'h0_0000_00ff);
        @(posedge core_clk_i);
        #1;
        check(36'(dec_valid), 36'h0);
        check(wr_data, 36'h0_0000_00ff);
        $display("test burst done");
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial begin
        miscompares = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        repeat (6) @(posedge core_clk_i);
        #1;
        test_reset();
        rst_i = 1'b0;
        test_pointers();
        test_single();
        test_alu();
        test_move();
        test_burst();
        summarize();
    end

    // watchdog: tests need well under 200 cycles
    initial begin
        #50us;
        miscompares++;
        summarize();
    end
endmodule

//--- testbench/orsd_core_model.sv
// behavioural model of the core decoder that presents operand decode requests
`timescale 1ns/10ps
module orsd_core_model (
    input  wire logic                core_clk_i,
    output logic                     req_valid_o,
    output orsd_pkg::orsd_field_type field_kind_o,
    output logic [4:0]               sel_idx_o,
    output logic                     is_dest_o,
    output logic                     first_access_o,
    output logic [15:0]              wr_word_o
);
    import orsd_pkg::*;
    // quiet request lines from time zero
    initial begin
        req_valid_o    = 1'b0;
        field_kind_o   = fk_pointer_set_with_stack;
        sel_idx_o      = 5'h00;
        is_dest_o      = 1'b0;
        first_access_o = 1'b0;
        wr_word_o      = 16'h0000;
    end
    // one request, launched 1 ns after an edge and taken at the next edge;
    // hold keeps valid up so the following request goes back to back
    task automatic send(input orsd_field_type k, input logic [4:0] s, input logic d,
                        input logic f, input logic [15:0] w, input logic hold);
        // an idle edge first so valid is never lowered and raised in one step
        if (req_valid_o !== 1'b1) begin
            @(posedge core_clk_i);
            #1;
        end
        req_valid_o    = 1'b1;
        field_kind_o   = k;
        sel_idx_o      = s;
        is_dest_o      = d;
        first_access_o = f;
        wr_word_o      = w;
        @(posedge core_clk_i);
        #1;
        if (!hold) begin
            req_valid_o = 1'b0;
        end
    endtask
endmodule
